/* File: shared/ssic_pkg.sv */
package ssic_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_SERIAL_BYTE = 4'hC;
    localparam logic [3:0] IDX_INT_CTRL = 4'hD;
    localparam logic [3:0] IDX_TIMER_ONE_CTRL = 4'hE;
    localparam logic [3:0] IDX_TIMER_TWO_CTRL = 4'hF;
    localparam logic [7:0] ADDR_SERIAL_BYTE = {2'h0, IDX_SERIAL_BYTE, 2'h0};
    localparam logic [7:0] ADDR_INT_CTRL = {2'h0, IDX_INT_CTRL, 2'h0};
    localparam logic [7:0] ADDR_TIMER_ONE_CTRL = {2'h0, IDX_TIMER_ONE_CTRL, 2'h0};
    localparam logic [7:0] ADDR_TIMER_TWO_CTRL = {2'h0, IDX_TIMER_TWO_CTRL, 2'h0};

    // timer control field positions
    localparam int CTL_START = 0;
    localparam int CTL_PORT_OUT_EN = 1;
    localparam int CTL_PULSE_TOGGLE = 2;
    localparam int CTL_ONE_SHOT = 3;
    localparam int CTL_FORCE_LOAD = 4;
    localparam int CTL_ONE_COUNT_SRC = 5;
    localparam int CTL_SERIAL_DIR = 6;
    localparam int CTL_MAINS_RATE = 7;
    localparam int CTL_TWO_SRC_LO = 5;
    localparam int CTL_TWO_SRC_HI = 6;
    localparam int CTL_ALARM_WRITE = 7;
    // stored control bits; force-load reads zero
    localparam logic [7:0] CTL_STORE_MASK = 8'hEF;

    // interrupt status positions
    localparam int INT_TIMER_ONE = 0;
    localparam int INT_TIMER_TWO = 1;
    localparam int INT_CLOCK_MATCH = 2;
    localparam int INT_SERIAL = 3;
    localparam int INT_EDGE_INPUT = 4;
    localparam int INT_SUMMARY = 7;
    localparam int INT_SET_CLEAR = 7;

    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_SERIAL_BYTE = 8'h00;
    localparam logic [4:0] RST_INT = 5'h00;

    // serial framing
    localparam logic [2:0] LAST_BIT = 3'h7;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // timer two count sources
    typedef enum logic [1:0] {
        SRC_SYS_CLOCK = 2'h0,
        SRC_PIN_EDGES = 2'h1,
        SRC_TIMER_ONE = 2'h2,
        SRC_TIMER_ONE_GATED = 2'h3
    } ssic_count_src_t;
endpackage : ssic_pkg

/* File: core/ssic_core.sv */
// Contract
// - serial_direction, timer_one_ctrl bit 6, picks output (1) or input (0).
// - input mode samples the data pin on each shift clock falling edge.
// - input mode stores the byte after 8 pulses and flags.
// - output mode shifts at half the timer one underflow rate.
// - output byte write starts sending only while timer one runs continuous.
// - output mode drives the derived shift clock on the clock pin.
// - sent data changes on shift clock rise and holds until next rise.
// - after 8 output pulses flag; a waiting byte continues without gap, but a byte write in that cycle sends eight zero bits first.
// - with nothing waiting, clock returns low and data holds last bit.
// - bytes go out most significant bit first.
// - status bits 0..4 are the five flags, bits 5,6 zero, bit 7 summary.
// - each event sets its flag regardless of its mask.
// - a masked-in event sets the summary flag and drives the request low.
// - reading status clears all flags except one set by a same-cycle event, and releases the request high unless that event is masked in.
// - mask write: bit 7 one sets, zero clears, the bits written as one.
// - clock writes go to alarm when alarm_write_select is one.
// - unused bits ignore writes and read as zero.
`timescale 1ns/1ps
`default_nettype none
module ssic_core (
    input wire logic clk_sys, // clock
    input wire logic resetn, // reset, active low
    input wire logic [7:0] s_axi_awaddr, // aw addr
    input wire logic s_axi_awvalid, // aw valid
    output logic s_axi_awready, // aw ready
    input wire logic [31:0] s_axi_wdata, // w data
    input wire logic [3:0] s_axi_wstrb, // w strobes
    input wire logic s_axi_wvalid, // w valid
    output logic s_axi_wready, // w ready
    output logic [1:0] s_axi_bresp, // b resp
    output logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic [7:0] s_axi_araddr, // ar addr
    input wire logic s_axi_arvalid, // ar valid
    output logic s_axi_arready, // ar ready
    output logic [31:0] s_axi_rdata, // r data
    output logic [1:0] s_axi_rresp, // r resp
    output logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic shiftClockPinIn, // clock pin level
    output logic shiftClockPinOut, // clock pin drive
    output logic shiftClockPinOe, // clock pin enable
    input wire logic serialDataPinIn, // data pin level
    output logic serialDataPinOut, // data pin drive
    output logic serialDataPinOe, // data pin enable
    input wire logic timerOneUnderflow, // timer one underflow
    input wire logic timerTwoUnderflow, // timer two underflow
    input wire logic clockMatchEvent, // alarm match
    input wire logic edgeInputEvent, // edge input
    output logic interruptRequestN, // request, active low
    output logic timerOneRun, // start one
    output logic timerTwoRun, // start two
    output logic timerOneForceLoad, // load one
    output logic timerTwoForceLoad, // load two
    output logic timerOneOneShot, // one-shot one
    output logic timerTwoOneShot, // one-shot two
    output logic timerOnePulseToggle, // toggle one
    output logic timerTwoPulseToggle, // toggle two
    output logic portOutputEnableOne, // port bit six drive
    output logic portOutputEnableTwo, // port bit seven drive
    output logic timerOneCountPin, // one counts pin
    output logic [1:0] timerTwoCountSource, // two source
    output logic timerTwoCountTick, // two count pulse
    output logic mainsRateSelect, // mains rate
    output logic alarmWriteSelect // writes go to alarm
);

    // register state
    logic [7:0] ctrlOne_q, ctrlOne_d;
    logic [7:0] ctrlTwo_q, ctrlTwo_d;
    logic [7:0] serialByte_q, serialByte_d;
    logic [4:0] intFlags_q, intFlags_d;
    logic [4:0] intMask_q, intMask_d;
    logic summary_q, summary_d;
    logic loadOne_q, loadOne_d;
    logic loadTwo_q, loadTwo_d;
    // bus state
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    // serial state
    logic [7:0] shifter_q, shifter_d;
    logic [2:0] bitCount_q, bitCount_d;
    logic txActive_q, txActive_d;
    logic txPending_q, txPending_d;
    logic clockOut_q, clockOut_d;
    logic dataOut_q, dataOut_d;
    logic pinPrev_q, pinPrev_d;

    logic wrFire, rdFire, wrByteEn;
    logic [7:0] wrData;
    logic outputMode, timerContinuous, pinFall, pinRise;
    logic rxDone, txDone, serialEvent, statusRead;
    logic [4:0] events;

    // decode of an aligned register address
    function automatic logic addrHit(input logic [7:0] addr, input logic [7:0] reg_addr);
        addrHit = (addr == reg_addr);
    endfunction : addrHit

    // keep only the stored control bits
    function automatic logic [7:0] ctrlStore(input logic [7:0] value);
        ctrlStore = value & ssic_pkg::CTL_STORE_MASK;
    endfunction : ctrlStore

    // bus handshakes
    assign wrFire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
    assign rdFire = s_axi_arvalid && !rvalid_q;
    assign s_axi_awready = wrFire;
    assign s_axi_wready = wrFire;
    assign s_axi_arready = rdFire;
    assign wrByteEn = wrFire && s_axi_wstrb[0];
    assign wrData = s_axi_wdata[7:0];
    assign statusRead = rdFire && addrHit(s_axi_araddr, ssic_pkg::ADDR_INT_CTRL);

    // mode decode
    assign outputMode = ctrlOne_q[ssic_pkg::CTL_SERIAL_DIR];
    assign timerContinuous = ctrlOne_q[ssic_pkg::CTL_START]
        && !ctrlOne_q[ssic_pkg::CTL_ONE_SHOT];
    assign pinFall = pinPrev_q && !shiftClockPinIn;
    assign pinRise = !pinPrev_q && shiftClockPinIn;

    // interrupt sources
    assign serialEvent = rxDone || txDone;
    always_comb begin
        events = '0;
        events[ssic_pkg::INT_TIMER_ONE] = timerOneUnderflow;
        events[ssic_pkg::INT_TIMER_TWO] = timerTwoUnderflow;
        events[ssic_pkg::INT_CLOCK_MATCH] = clockMatchEvent;
        events[ssic_pkg::INT_SERIAL] = serialEvent;
        events[ssic_pkg::INT_EDGE_INPUT] = edgeInputEvent;
    end

    // register file next state
    always_comb begin
        ctrlOne_d = ctrlOne_q;
        ctrlTwo_d = ctrlTwo_q;
        intMask_d = intMask_q;
        loadOne_d = 1'b0;
        loadTwo_d = 1'b0;
        if (wrByteEn && addrHit(s_axi_awaddr, ssic_pkg::ADDR_TIMER_ONE_CTRL)) begin
            ctrlOne_d = ctrlStore(wrData);
            loadOne_d = wrData[ssic_pkg::CTL_FORCE_LOAD];
        end
        if (wrByteEn && addrHit(s_axi_awaddr, ssic_pkg::ADDR_TIMER_TWO_CTRL)) begin
            ctrlTwo_d = ctrlStore(wrData);
            loadTwo_d = wrData[ssic_pkg::CTL_FORCE_LOAD];
        end
        // one-shot underflow stops the timer
        if (timerOneUnderflow && ctrlOne_q[ssic_pkg::CTL_ONE_SHOT]) begin
            ctrlOne_d[ssic_pkg::CTL_START] = 1'b0;
        end
        if (timerTwoUnderflow && ctrlTwo_q[ssic_pkg::CTL_ONE_SHOT]) begin
            ctrlTwo_d[ssic_pkg::CTL_START] = 1'b0;
        end
        if (wrByteEn && addrHit(s_axi_awaddr, ssic_pkg::ADDR_INT_CTRL)) begin
            if (wrData[ssic_pkg::INT_SET_CLEAR]) begin
                intMask_d = intMask_q | wrData[4:0];
            end else begin
                intMask_d = intMask_q & ~wrData[4:0];
            end
        end
        // read clears, a same-cycle event still lands
        intFlags_d = (statusRead ? ssic_pkg::RST_INT : intFlags_q) | events;
        summary_d = (statusRead ? 1'b0 : summary_q) | (|(events & intMask_q));
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrlOne_q <= ssic_pkg::RST_CTRL;
            ctrlTwo_q <= ssic_pkg::RST_CTRL;
            intMask_q <= ssic_pkg::RST_INT;
            intFlags_q <= ssic_pkg::RST_INT;
            summary_q <= 1'b0;
            loadOne_q <= 1'b0;
            loadTwo_q <= 1'b0;
        end else begin
            ctrlOne_q <= ctrlOne_d;
            ctrlTwo_q <= ctrlTwo_d;
            intMask_q <= intMask_d;
            intFlags_q <= intFlags_d;
            summary_q <= summary_d;
            loadOne_q <= loadOne_d;
            loadTwo_q <= loadTwo_d;
        end
    end

    // bus answers one cycle after acceptance
    always_comb begin
        bvalid_d = bvalid_q && !s_axi_bready;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q && !s_axi_rready;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (wrFire) begin
            bvalid_d = 1'b1;
            bresp_d = (addrHit(s_axi_awaddr, ssic_pkg::ADDR_SERIAL_BYTE)
                || addrHit(s_axi_awaddr, ssic_pkg::ADDR_INT_CTRL)
                || addrHit(s_axi_awaddr, ssic_pkg::ADDR_TIMER_ONE_CTRL)
                || addrHit(s_axi_awaddr, ssic_pkg::ADDR_TIMER_TWO_CTRL))
                ? ssic_pkg::RESP_OKAY : ssic_pkg::RESP_DECERR;
        end
        if (rdFire) begin
            rvalid_d = 1'b1;
            rresp_d = ssic_pkg::RESP_OKAY;
            rdata_d = 32'h0000_0000;
            unique case (1'b1)
                addrHit(s_axi_araddr, ssic_pkg::ADDR_SERIAL_BYTE): begin
                    rdata_d[7:0] = serialByte_q;
                end
                addrHit(s_axi_araddr, ssic_pkg::ADDR_INT_CTRL): begin
                    rdata_d[7:0] = {summary_q, 2'h0, intFlags_q};
                end
                addrHit(s_axi_araddr, ssic_pkg::ADDR_TIMER_ONE_CTRL): begin
                    rdata_d[7:0] = ctrlOne_q;
                end
                addrHit(s_axi_araddr, ssic_pkg::ADDR_TIMER_TWO_CTRL): begin
                    rdata_d[7:0] = ctrlTwo_q;
                end
                default: begin
                    rresp_d = ssic_pkg::RESP_DECERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= ssic_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= ssic_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // serial shifter, both directions
    always_comb begin
        serialByte_d = serialByte_q;
        shifter_d = shifter_q;
        bitCount_d = bitCount_q;
        txActive_d = txActive_q;
        txPending_d = txPending_q;
        clockOut_d = clockOut_q;
        dataOut_d = dataOut_q;
        pinPrev_d = shiftClockPinIn;
        rxDone = 1'b0;
        txDone = 1'b0;
        if (wrByteEn && addrHit(s_axi_awaddr, ssic_pkg::ADDR_SERIAL_BYTE)) begin
            serialByte_d = wrData;
            txPending_d = outputMode;
        end
        if (!outputMode) begin
            txActive_d = 1'b0;
            txPending_d = 1'b0;
            clockOut_d = 1'b0;
            if (pinFall) begin
                shifter_d = {shifter_q[6:0], serialDataPinIn};
                bitCount_d = bitCount_q + 3'h1;
                if (bitCount_q == ssic_pkg::LAST_BIT) begin
                    serialByte_d = {shifter_q[6:0], serialDataPinIn};
                    rxDone = 1'b1;
                end
            end
        end else if (!txActive_q) begin
            bitCount_d = 3'h0;
            // start only with timer one free-running
            if (txPending_q && timerContinuous) begin
                shifter_d = serialByte_q;
                txPending_d = 1'b0;
                txActive_d = 1'b1;
            end
        end else if (timerOneUnderflow) begin
            clockOut_d = !clockOut_q;
            if (!clockOut_q) begin
                dataOut_d = shifter_q[7];
            end else begin
                shifter_d = {shifter_q[6:0], 1'b0};
                bitCount_d = bitCount_q + 3'h1;
                if (bitCount_q == ssic_pkg::LAST_BIT) begin
                    txDone = 1'b1;
                    if (txPending_q && !(wrByteEn && addrHit(s_axi_awaddr,
                        ssic_pkg::ADDR_SERIAL_BYTE))) begin
                        shifter_d = serialByte_q;
                        txPending_d = 1'b0;
                    end else if (!txPending_q) begin
                        txActive_d = 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            serialByte_q <= ssic_pkg::RST_SERIAL_BYTE;
            shifter_q <= 8'h00;
            bitCount_q <= 3'h0;
            txActive_q <= 1'b0;
            txPending_q <= 1'b0;
            clockOut_q <= 1'b0;
            dataOut_q <= 1'b0;
            pinPrev_q <= 1'b0;
        end else begin
            serialByte_q <= serialByte_d;
            shifter_q <= shifter_d;
            bitCount_q <= bitCount_d;
            txActive_q <= txActive_d;
            txPending_q <= txPending_d;
            clockOut_q <= clockOut_d;
            dataOut_q <= dataOut_d;
            pinPrev_q <= pinPrev_d;
        end
    end

    // timer two count selection
    always_comb begin
        unique case (ssic_pkg::ssic_count_src_t'(ctrlTwo_q[6:5]))
            ssic_pkg::SRC_SYS_CLOCK: timerTwoCountTick = 1'b1;
            ssic_pkg::SRC_PIN_EDGES: timerTwoCountTick = pinRise;
            ssic_pkg::SRC_TIMER_ONE: timerTwoCountTick = timerOneUnderflow;
            ssic_pkg::SRC_TIMER_ONE_GATED: begin
                timerTwoCountTick = timerOneUnderflow && shiftClockPinIn;
            end
        endcase
    end

    // output wiring
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign shiftClockPinOut = clockOut_q;
    assign shiftClockPinOe = outputMode;
    assign serialDataPinOut = dataOut_q;
    assign serialDataPinOe = outputMode;
    assign interruptRequestN = !summary_q;
    assign timerOneRun = ctrlOne_q[ssic_pkg::CTL_START];
    assign timerTwoRun = ctrlTwo_q[ssic_pkg::CTL_START];
    assign timerOneForceLoad = loadOne_q;
    assign timerTwoForceLoad = loadTwo_q;
    assign timerOneOneShot = ctrlOne_q[ssic_pkg::CTL_ONE_SHOT];
    assign timerTwoOneShot = ctrlTwo_q[ssic_pkg::CTL_ONE_SHOT];
    assign timerOnePulseToggle = ctrlOne_q[ssic_pkg::CTL_PULSE_TOGGLE];
    assign timerTwoPulseToggle = ctrlTwo_q[ssic_pkg::CTL_PULSE_TOGGLE];
    assign portOutputEnableOne = ctrlOne_q[ssic_pkg::CTL_PORT_OUT_EN];
    assign portOutputEnableTwo = ctrlTwo_q[ssic_pkg::CTL_PORT_OUT_EN];
    assign timerOneCountPin = ctrlOne_q[ssic_pkg::CTL_ONE_COUNT_SRC];
    assign timerTwoCountSource = ctrlTwo_q[ssic_pkg::CTL_TWO_SRC_HI:ssic_pkg::CTL_TWO_SRC_LO];
    assign mainsRateSelect = ctrlOne_q[ssic_pkg::CTL_MAINS_RATE];
    assign alarmWriteSelect = ctrlTwo_q[ssic_pkg::CTL_ALARM_WRITE];

endmodule : ssic_core
`default_nettype wire

/* File: verification/ssic_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module ssic_core_monitor (
    input wire logic clk_sys, // system clock
    input wire logic resetn, // reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    input wire logic s_axi_bvalid, // write response valid
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    input wire logic [31:0] s_axi_rdata, // read data
    input wire logic s_axi_rvalid, // read data valid
    input wire logic shiftClockPinOut, // shift clock drive
    input wire logic shiftClockPinOe, // shift clock enable
    input wire logic serialDataPinOut, // data drive
    input wire logic serialDataPinOe, // data enable
    input wire logic timerOneUnderflow, // timer one underflow
    input wire logic interruptRequestN, // request, active low
    input wire logic timerOneRun, // timer one start
    input wire logic timerOneOneShot, // one-shot select
    input wire logic timerOneForceLoad, // timer one load pulse
    input wire logic timerTwoForceLoad, // timer two load pulse
    input wire logic [1:0] timerTwoCountSource, // timer two source
    input wire logic timerTwoCountTick // timer two tick
);
    logic wrAny, wrOne, wrTwo;
    // control writes taken this cycle
    assign wrAny = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_wstrb[0];
    assign wrOne = wrAny && s_axi_awaddr == ssic_pkg::ADDR_TIMER_ONE_CTRL;
    assign wrTwo = wrAny && s_axi_awaddr == ssic_pkg::ADDR_TIMER_TWO_CTRL;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // pins, strobes and status relations
    a_pins_same_dir: assert property (serialDataPinOe == shiftClockPinOe)
        else $error("pin enables disagree");
    a_clk_from_timer: assert property (shiftClockPinOe && $past(shiftClockPinOe)
        && $changed(shiftClockPinOut) |-> $past(timerOneUnderflow))
        else $error("shift clock moved without underflow");
    a_data_on_rise: assert property (serialDataPinOe && $past(serialDataPinOe)
        && $changed(serialDataPinOut) |-> $rose(shiftClockPinOut))
        else $error("data changed off a clock rise");
    a_load_one: assert property (timerOneForceLoad == $past(wrOne && s_axi_wdata[4]))
        else $error("timer one load pulse wrong");
    a_load_two: assert property (timerTwoForceLoad == $past(wrTwo && s_axi_wdata[4]))
        else $error("timer two load pulse wrong");
    a_stop_cause: assert property ($fell(timerOneRun) |-> $past(wrOne)
        || $past(timerOneUnderflow && timerOneOneShot))
        else $error("timer one stopped without cause");
    a_tick_free: assert property (timerTwoCountSource == 2'h0 |-> timerTwoCountTick)
        else $error("free count tick missing");
    a_tick_timer: assert property (timerTwoCountSource == 2'h2
        |-> timerTwoCountTick == timerOneUnderflow)
        else $error("timer count tick wrong");
    a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read upper bits not zero");
    a_summary_read: assert property (s_axi_arvalid && !s_axi_rvalid
        && s_axi_araddr == ssic_pkg::ADDR_INT_CTRL
        |=> s_axi_rdata[7] == !$past(interruptRequestN))
        else $error("summary bit and request disagree");
endmodule : ssic_core_monitor

bind ssic_core ssic_core_monitor mon (.*);
`default_nettype wire

/* File: verification/ssic_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module ssic_peer (
    input wire logic clk_sys, // system clock
    input wire logic lineClk, // shift clock wire level
    input wire logic lineData, // serial data wire level
    output logic peerClk, // clock driven as remote master
    output logic peerData, // data driven as remote sender
    output logic [15:0] rxWord // last sixteen bits received
);
    logic clkPrev;
    // idle: clock still and low
    initial begin
        peerClk = 1'b0;
        peerData = 1'b1;
        rxWord = 16'h0000;
        clkPrev = 1'b0;
    end
    // sample on each clock fall
    always @(posedge clk_sys) begin
        clkPrev <= lineClk;
        if (clkPrev && !lineClk) begin
            rxWord <= {rxWord[14:0], lineData};
        end
    end
    // send msb first
    task automatic send_byte(input logic [7:0] b, input int half);
        for (int i = 7; i >= 0; i--) begin
            peerData <= b[i];
            repeat (half) @(posedge clk_sys);
            peerClk <= 1'b1;
            repeat (half) @(posedge clk_sys);
            peerClk <= 1'b0;
            repeat (half) @(posedge clk_sys);
        end
        peerData <= ~b[0];
    endtask : send_byte
endmodule : ssic_peer
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, evt;
    logic [1:0] s_axi_bresp, s_axi_rresp, timerTwoCountSource;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic shiftClockPinOut, shiftClockPinOe, serialDataPinOut, serialDataPinOe;
    logic interruptRequestN, timerOneRun, timerTwoRun, timerOneForceLoad, timerTwoForceLoad;
    logic timerOneOneShot, timerTwoOneShot, timerOnePulseToggle, timerTwoPulseToggle;
    logic portOutputEnableOne, portOutputEnableTwo, timerOneCountPin, timerTwoCountTick;
    logic mainsRateSelect, alarmWriteSelect, ufOn, ufTick, peerClk, peerData;
    logic [15:0] rxWord;
    int n_mismatch, n_compared, cycles;
    // shared pins resolved from both drivers
    wire logic shiftClockPinIn = shiftClockPinOe ? shiftClockPinOut : peerClk;
    wire logic serialDataPinIn = serialDataPinOe ? serialDataPinOut : peerData;
    wire logic timerOneUnderflow = evt[0] | ufTick;
    wire logic timerTwoUnderflow = evt[1];
    wire logic clockMatchEvent = evt[2];
    wire logic edgeInputEvent = evt[3];

    ssic_core dut (.*);
    ssic_peer peer (.clk_sys(clk_sys), .lineClk(shiftClockPinIn), .lineData(serialDataPinIn),
        .peerClk(peerClk), .peerData(peerData), .rxWord(rxWord));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // underflow every other cycle; hang ceiling
    always @(posedge clk_sys) begin
        ufTick <= ufOn && !ufTick;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // r: 0 serial, 1 int, 2 ctl one, 3 ctl two, 4 unmapped
    task automatic wr(input int r, input logic [7:0] d, input logic [1:0] er = 2'h0);
        logic aw, w;
        {aw, w} = 2'h3;
        s_axi_awaddr <= ssic_pkg::ADDR_SERIAL_BYTE + 8'(4 * r);
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (!s_axi_bvalid);
        check("bresp", s_axi_bresp, er);
    endtask : wr
    task automatic rd_chk(input int r, input logic [7:0] exp, input logic [1:0] er = 2'h0);
        s_axi_araddr <= ssic_pkg::ADDR_SERIAL_BYTE + 8'(4 * r);
        s_axi_arvalid <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk_sys); while (!s_axi_rvalid);
        check("rdata", s_axi_rdata, {24'h0, exp});
        check("rresp", s_axi_rresp, er);
    endtask : rd_chk
    task automatic pulse(input int k);
        evt[k] <= 1'b1;
        @(posedge clk_sys);
        evt[k] <= 1'b0;
        @(posedge clk_sys);
    endtask : pulse
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : give_verdict

    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, evt, ufOn} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        {n_mismatch, n_compared, cycles} = '0;
        resetn = 1'b0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        // reset values and unmapped place
        for (int r = 0; r < 4; r++) rd_chk(r, 8'h00);
        rd_chk(4, 8'h00, ssic_pkg::RESP_DECERR);
        wr(4, 8'hFF, ssic_pkg::RESP_DECERR);
        $display("test reset done");
        // control bits stored, load strobe reads zero
        wr(2, 8'hFF);
        check("ctlOne", {timerOneRun, timerOneOneShot, serialDataPinOe, timerOnePulseToggle,
            portOutputEnableOne, timerOneCountPin, mainsRateSelect}, 7'h7F);
        rd_chk(2, 8'hEF);
        wr(3, 8'hFF);
        check("ctlTwo", {alarmWriteSelect, timerTwoRun, timerTwoOneShot, timerTwoPulseToggle,
            portOutputEnableTwo}, 5'h1F);
        rd_chk(3, 8'hEF);
        for (int s = 0; s < 4; s++) begin
            wr(3, 8'(s << 5));
            check("srcSel", timerTwoCountSource, 32'(s));
        end
        wr(2, 8'h00);
        check("dataOe", serialDataPinOe, 1'b0);
        $display("test controls done");
        // flags without mask, then timer one, timer two, alarm and edge sources masked in
        pulse(1);
        check("irqN", interruptRequestN, 1'b1);
        rd_chk(1, 8'h02);
        rd_chk(1, 8'h00);
        wr(1, 8'h9F);
        for (int k = 0; k < 4; k++) begin
            pulse(k);
            check("irqN", interruptRequestN, 1'b0);
            rd_chk(1, 8'h80 | (8'h01 << ((k == 3) ? 4 : k)));
            check("irqN", interruptRequestN, 1'b1);
        end
        wr(1, 8'h04);
        pulse(2);
        check("irqN", interruptRequestN, 1'b1);
        pulse(3);
        check("irqN", interruptRequestN, 1'b0);
        rd_chk(1, 8'h94);
        $display("test interrupts done");
        // remote master sends, fast then slow
        for (int k = 0; k < 2; k++) begin
            peer.send_byte(k ? 8'h3C : 8'hA5, k ? 5 : 2);
            repeat (8) @(posedge clk_sys);
            rd_chk(0, k ? 8'h3C : 8'hA5);
            rd_chk(1, 8'h88);
        end
        $display("test serial input done");
        // two bytes out back to back
        wr(2, 8'h41);
        ufOn <= 1'b1;
        wr(0, 8'hC3);
        wr(0, 8'h5A);
        repeat (80) @(posedge clk_sys);
        ufOn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("rxWord", rxWord, 16'hC35A);
        check("pinsIdle", {shiftClockPinOut, serialDataPinOut}, 2'h0);
        rd_chk(1, 8'h89);
        // one-shot timer must not start sending
        wr(2, 8'h49);
        wr(0, 8'hFF);
        ufOn <= 1'b1;
        repeat (40) @(posedge clk_sys);
        ufOn <= 1'b0;
        @(posedge clk_sys);
        check("rxWord", rxWord, 16'hC35A);
        check("oneRun", timerOneRun, 1'b0);
        $display("test serial output done");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
